// [fmtdl_pkg.sv]
// constants and carriers for the format command and defect list decoder
package fmtdl_pkg;
  localparam logic [7:0] OPC_FORMAT = 8'h04;
  localparam int CDB_LAST = 5;
  localparam int HDR_LAST = 3;
  localparam int FLAG_LIST_FOLLOWS = 4;
  localparam int FLAG_COMPLETE_LIST = 3;
  localparam int FLAG_OPTIONS_VALID = 7;
  localparam int FLAG_PRIMARY_DISABLE = 6;
  localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_BAD_OP = 8'h20;
  localparam logic [7:0] ASC_BAD_CDB = 8'h24;
  localparam logic [7:0] ASC_BAD_LIST = 8'h26;
  localparam int CYL_SHIFT = 8;
  localparam logic [31:0] SPARES_PER_CYL = 32'h0000_0004;
  localparam int GROWN_DEPTH = 16;
  localparam int GROWN_AW = 4;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [31:0] lba;
    logic [31:0] phys;
    logic slip;
  } fmtdl_defect_t;

  typedef struct packed {
    logic usePrimary;
    logic useGrown;
    logic useSupplied;
    logic clearGrown;
    logic fillEn;
    logic [7:0] fillPat;
  } fmtdl_sel_t;
endpackage : fmtdl_pkg

// [fmtdl_decoder.sv]
// format command and defect list decoder, drive side
//
// What this block does
// - opcode 04h in byte 0 is recognised as the format command
// - byte 1: unit and list format must be zero; bit4 follows, bit3 complete
// - list-follows one: enter data-out phase after command, accept defect list
// - list-follows zero: no data-out phase, no header or descriptors requested
// - each received block address is translated to physical and stored until the grown list holds GROWN_DEPTH entries
// - complete-list one with list-follows one discards old grown list and builds new one; without a list it is ignored
// - complete-list zero appends supplied defects to existing grown list
// - byte 2 is fill pattern, used only when mode page option enables it
// - interleave bytes 3 and 4 ignored, format always 1:1
// - list opens with four-byte header: reserved, options, length MSB first
// - options-valid one honours primary-disable; zero applies default scheme if primary-disable is zero, else list rejected
// - primary-disable one excludes factory list; zero includes it
// - other six option bits have no effect
// - length is descriptor bytes, four per descriptor; zero is legal
// - descriptor is four-byte address MSB first; sector marked bad, redirected
// - zero length, follows and complete: no defects, or factory only
// - zero length, not complete, options: grown only; no list: factory and grown
// - nonzero length, complete: provided only, or provided plus factory
// - nonzero length, not complete: provided plus grown, or plus all
// - defect with spare left on cylinder slips following blocks by one
// - invalid command field ends with key 5h code 24h, media untouched
`timescale 1ns/10ps
module fmtdl_decoder import fmtdl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command and data-out bytes from the bus
  input wire logic inValid,
  output logic inReady,
  input wire logic [7:0] inByte,
  output logic dataOutReq,
  // mode page option
  input wire logic fillModeEn,
  // defect map entries
  output logic outValid,
  input wire logic outReady,
  output fmtdl_defect_t outDefect,
  // format result
  output logic fmtGo,
  output fmtdl_sel_t fmtSel,
  output logic chkCond,
  output logic [3:0] senseKey,
  output logic [7:0] senseAsc,
  // grown list status
  output logic [GROWN_AW:0] growCount,
  output logic growFull
);
  default clocking cb_dflt @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // helpers
  // ****************************************
  // a cylinder holds 2^CYL_SHIFT data blocks followed by its spares
  function automatic logic [31:0] cylOf(input logic [31:0] lba);
    cylOf = lba >> CYL_SHIFT;
  endfunction : cylOf
  function automatic logic [31:0] lba2phys(input logic [31:0] lba);
    lba2phys = lba + 32'(cylOf(lba) * SPARES_PER_CYL);
  endfunction : lba2phys

  // ****************************************
  // two-entry buffer toward the defect map
  // ****************************************
  fmtdl_defect_t bufMem_ff [BUF_DEPTH];
  logic wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [1:0] bufCnt_ff, nxt_bufCnt;
  logic push, pop;
  fmtdl_defect_t pushData;
  assign outValid = (bufCnt_ff != 2'h0);
  assign outDefect = bufMem_ff[rp_ff];
  assign pop = outValid && outReady;
  always_comb begin
    nxt_wp = push ? ~wp_ff : wp_ff;
    nxt_rp = pop ? ~rp_ff : rp_ff;
    nxt_bufCnt = bufCnt_ff + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      bufCnt_ff <= 2'h0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      bufCnt_ff <= nxt_bufCnt;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      bufMem_ff[wp_ff] <= pushData;
    end
  end

  // ****************************************
  // command and list decoder
  // ****************************************
  typedef enum logic [1:0] {ST_CMD, ST_HDR, ST_DESC} fmtdl_state_t;
  fmtdl_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic lf_ff, nxt_lf, cmp_ff, nxt_cmp, fov_ff, nxt_fov, primary_disable_bit_ff, nxt_primary_disable_bit;
  logic badOp_ff, nxt_badOp, badCdb_ff, nxt_badCdb, badHdr_ff, nxt_badHdr;
  logic [7:0] pat_ff, nxt_pat, asc_ff, nxt_asc;
  logic [15:0] len_ff, nxt_len;
  logic [31:0] acc_ff, nxt_acc, lastCyl_ff, nxt_lastCyl, cylUse_ff, nxt_cylUse;
  logic go_ff, nxt_go, chk_ff, nxt_chk;
  fmtdl_sel_t sel_ff, nxt_sel;
  logic [GROWN_AW:0] grow_ff, nxt_grow;
  logic [31:0] grown_ff [GROWN_DEPTH];
  logic growWr, take, sameCyl;
  logic [31:0] lbaNow;
  // a full buffer stalls the list rather than dropping a descriptor
  assign inReady = (state_ff != ST_DESC) || (bufCnt_ff != 2'(BUF_DEPTH));
  assign take = inValid && inReady;
  assign dataOutReq = (state_ff != ST_CMD);
  assign lbaNow = {acc_ff[23:0], inByte};
  assign sameCyl = (cylOf(lbaNow) == lastCyl_ff) && (cylUse_ff != 32'h0);
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_lf = lf_ff;
    nxt_cmp = cmp_ff;
    nxt_fov = fov_ff;
    nxt_primary_disable_bit = primary_disable_bit_ff;
    nxt_badOp = badOp_ff;
    nxt_badCdb = badCdb_ff;
    nxt_badHdr = badHdr_ff;
    nxt_pat = pat_ff;
    nxt_asc = asc_ff;
    nxt_len = len_ff;
    nxt_acc = acc_ff;
    nxt_lastCyl = lastCyl_ff;
    nxt_cylUse = cylUse_ff;
    nxt_go = 1'b0;
    nxt_chk = 1'b0;
    nxt_sel = sel_ff;
    nxt_grow = grow_ff;
    push = 1'b0;
    growWr = 1'b0;
    pushData = '0;
    if (take) begin
      case (state_ff)
        ST_CMD: begin
          nxt_cnt = cnt_ff + 16'h0001;
          case (cnt_ff)
            16'h0000: begin
              nxt_badOp = (inByte != OPC_FORMAT);
              nxt_badCdb = 1'b0;
            end
            16'h0001: begin
              nxt_lf = inByte[FLAG_LIST_FOLLOWS];
              nxt_cmp = inByte[FLAG_COMPLETE_LIST];
              nxt_badCdb = (inByte[7:5] != 3'h0) || (inByte[2:0] != 3'h0);
            end
            16'h0002: nxt_pat = inByte;
            16'h0005: begin
              // interleave bytes never reach any state: always 1:1
              nxt_cnt = 16'h0000;
              if (badOp_ff || badCdb_ff || inByte != 8'h00) begin
                nxt_chk = 1'b1;
                nxt_asc = badOp_ff ? ASC_BAD_OP : ASC_BAD_CDB;
              end else if (lf_ff) begin
                nxt_state = ST_HDR;
              end else begin
                nxt_go = 1'b1;
                nxt_sel = '{1'b1, 1'b1, 1'b0, 1'b0, fillModeEn, pat_ff};
              end
            end
            default: ;
          endcase
        end
        ST_HDR: begin
          nxt_cnt = cnt_ff + 16'h0001;
          case (cnt_ff)
            16'h0000: nxt_badHdr = (inByte != 8'h00);
            16'h0001: begin
              // the six other option bits are dropped here
              nxt_fov = inByte[FLAG_OPTIONS_VALID];
              nxt_primary_disable_bit = inByte[FLAG_PRIMARY_DISABLE];
            end
            16'h0002: nxt_len = {inByte, 8'h00};
            default: begin
              nxt_len = {len_ff[15:8], inByte};
              nxt_cnt = {len_ff[15:8], inByte};
              nxt_cylUse = 32'h0;
              if (badHdr_ff || inByte[1:0] != 2'h0 || (primary_disable_bit_ff && !fov_ff)) begin
                nxt_chk = 1'b1;
                nxt_asc = ASC_BAD_LIST;
                nxt_state = ST_CMD;
                nxt_cnt = 16'h0000;
              end else begin
                nxt_grow = cmp_ff ? '0 : grow_ff;
                nxt_sel.usePrimary = !(fov_ff && primary_disable_bit_ff);
                nxt_sel.useGrown = !cmp_ff;
                nxt_sel.clearGrown = cmp_ff;
                nxt_sel.fillEn = fillModeEn;
                nxt_sel.fillPat = pat_ff;
                nxt_sel.useSupplied = ({len_ff[15:8], inByte} != 16'h0000);
                nxt_go = ({len_ff[15:8], inByte} == 16'h0000);
                nxt_state = nxt_go ? ST_CMD : ST_DESC;
              end
            end
          endcase
        end
        ST_DESC: begin
          nxt_acc = lbaNow;
          nxt_cnt = cnt_ff - 16'h0001;
          if (cnt_ff[1:0] == 2'h1) begin
            // spares on a cylinder absorb its first SPARES_PER_CYL defects in a row by slipping one block each
            nxt_cylUse = sameCyl ? cylUse_ff + 32'h1 : 32'h1;
            nxt_lastCyl = cylOf(lbaNow);
            push = 1'b1;
            pushData = '{lbaNow, lba2phys(lbaNow), nxt_cylUse <= SPARES_PER_CYL};
            if (grow_ff != (GROWN_AW+1)'(GROWN_DEPTH)) begin
              growWr = 1'b1;
              nxt_grow = grow_ff + 1'b1;
            end
            if (cnt_ff == 16'h0001) begin
              nxt_go = 1'b1;
              nxt_state = ST_CMD;
              nxt_cnt = 16'h0000;
            end
          end
        end
        default: nxt_state = ST_CMD;
      endcase
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_CMD;
      cnt_ff <= 16'h0000;
      lf_ff <= 1'b0;
      cmp_ff <= 1'b0;
      fov_ff <= 1'b0;
      primary_disable_bit_ff <= 1'b0;
      badOp_ff <= 1'b0;
      badCdb_ff <= 1'b0;
      badHdr_ff <= 1'b0;
      pat_ff <= 8'h00;
      asc_ff <= 8'h00;
      len_ff <= 16'h0000;
      acc_ff <= 32'h0;
      lastCyl_ff <= 32'h0;
      cylUse_ff <= 32'h0;
      go_ff <= 1'b0;
      chk_ff <= 1'b0;
      sel_ff <= '0;
      grow_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      lf_ff <= nxt_lf;
      cmp_ff <= nxt_cmp;
      fov_ff <= nxt_fov;
      primary_disable_bit_ff <= nxt_primary_disable_bit;
      badOp_ff <= nxt_badOp;
      badCdb_ff <= nxt_badCdb;
      badHdr_ff <= nxt_badHdr;
      pat_ff <= nxt_pat;
      asc_ff <= nxt_asc;
      len_ff <= nxt_len;
      acc_ff <= nxt_acc;
      lastCyl_ff <= nxt_lastCyl;
      cylUse_ff <= nxt_cylUse;
      go_ff <= nxt_go;
      chk_ff <= nxt_chk;
      sel_ff <= nxt_sel;
      grow_ff <= nxt_grow;
    end
  end
  always_ff @(posedge clk) begin
    if (growWr) begin
      grown_ff[grow_ff[GROWN_AW-1:0]] <= pushData.phys;
    end
  end
  assign fmtGo = go_ff;
  assign fmtSel = sel_ff;
  assign chkCond = chk_ff;
  assign senseKey = chk_ff ? SENSE_ILLEGAL : 4'h0;
  assign senseAsc = chk_ff ? asc_ff : 8'h00;
  assign growCount = grow_ff;
  assign growFull = (grow_ff == (GROWN_AW+1)'(GROWN_DEPTH));
  // ****************************************
  // assertions
  // ****************************************
  property p_badop;
    take && state_ff == ST_CMD && cnt_ff == 16'h0005 && badOp_ff
      |=> chkCond && senseAsc == ASC_BAD_OP && !fmtGo;
  endproperty
  a_badop: assert property (p_badop) else $error("bad opcode not reported");
  property p_badcdb;
    take && state_ff == ST_CMD && cnt_ff == 16'h0005 && !badOp_ff && badCdb_ff
      |=> chkCond && senseKey == SENSE_ILLEGAL && senseAsc == ASC_BAD_CDB;
  endproperty
  a_badcdb: assert property (p_badcdb) else $error("bad command field not reported");
  property p_enter_dout;
    take && state_ff == ST_CMD && cnt_ff == 16'h0005 && inByte == 8'h00 && !badOp_ff
      && !badCdb_ff && lf_ff |=> dataOutReq;
  endproperty
  a_enter_dout: assert property (p_enter_dout) else $error("no data-out phase");
  property p_no_dout;
    dataOutReq |-> lf_ff;
  endproperty
  a_no_dout: assert property (p_no_dout) else $error("data-out without list");
  property p_nolist_sel;
    fmtGo && !lf_ff |-> fmtSel.usePrimary && fmtSel.useGrown && !fmtSel.useSupplied;
  endproperty
  a_nolist_sel: assert property (p_nolist_sel) else $error("wrong no-list selection");
  property p_primary;
    fmtGo && lf_ff |-> fmtSel.usePrimary == !(fov_ff && primary_disable_bit_ff);
  endproperty
  a_primary: assert property (p_primary) else $error("primary selection wrong");
  property p_grown;
    fmtGo && lf_ff |-> fmtSel.useGrown == !cmp_ff && fmtSel.clearGrown == cmp_ff;
  endproperty
  a_grown: assert property (p_grown) else $error("grown selection wrong");
  property p_badlen;
    take && state_ff == ST_HDR && cnt_ff == 16'h0003 && inByte[1:0] != 2'h0
      |=> chkCond && senseAsc == ASC_BAD_LIST && !dataOutReq;
  endproperty
  a_badlen: assert property (p_badlen) else $error("bad list length accepted");
  property p_hold;
    outValid && !outReady |=> outValid && $stable(outDefect);
  endproperty
  a_hold: assert property (p_hold) else $error("buffered defect lost");
  c_nolist: cover property (fmtGo && !lf_ff);
  c_list: cover property (fmtGo && fmtSel.useSupplied);
  c_stall: cover property (!inReady && inValid);
  c_err: cover property (chkCond);
endmodule : fmtdl_decoder

// [fmtdl_initiator.sv]
// initiator model: feeds command and data-out bytes, drains defect entries
`timescale 1ns/10ps
module fmtdl_initiator (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // byte stream towards the drive
  output logic inValid,
  input wire logic inReady,
  output logic [7:0] inByte,
  // defect entries from the drive
  output logic outReady,
  input wire logic slowMode
);
  logic [7:0] q[$];
  logic [1:0] pace;

  task automatic send(input logic [7:0] b);
    q.push_back(b);
  endtask : send

  // byte held until taken; an idle bus inverts the last byte again on every cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inValid <= 1'b0;
      inByte <= 8'h00;
    end else if (!inValid || inReady) begin
      if (q.size() > 0) begin
        inValid <= 1'b1;
        inByte <= q.pop_front();
      end else begin
        inValid <= 1'b0;
        inByte <= ~inByte;
      end
    end
  end

  // slow mode takes one entry in four cycles, as often as a four-byte descriptor arrives, so the drive's buffer never fills
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pace <= 2'h0;
      outReady <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      outReady <= !slowMode || (pace == 2'h3);
    end
  end
endmodule : fmtdl_initiator

// [fmtdl_decoder_test.sv]
// self-checking testbench for the format command and defect list decoder
`timescale 1ns/10ps
module fmtdl_decoder_test import fmtdl_pkg::*; ;
  localparam int WATCH_NS = 400000;
  logic clk, sys_rst, inValid, inReady, dataOutReq, fillModeEn, outValid, outReady;
  logic fmtGo, chkCond, growFull, slowMode, reqSeen;
  logic [7:0] inByte, senseAsc, ascSeen;
  logic [3:0] senseKey, keySeen;
  logic [GROWN_AW:0] growCount;
  fmtdl_defect_t outDefect;
  fmtdl_sel_t fmtSel, selSeen, e;
  logic [31:0] seed, r, slipCyl;
  logic [31:0] got[$];
  logic [31:0] expQ[$];
  int n_errors, num_checks, goCnt, chkCnt, gcExp, slipUse;

  fmtdl_decoder dut_u (.clk(clk), .sys_rst(sys_rst), .inValid(inValid), .inReady(inReady),
    .inByte(inByte), .dataOutReq(dataOutReq), .fillModeEn(fillModeEn), .outValid(outValid),
    .outReady(outReady), .outDefect(outDefect), .fmtGo(fmtGo), .fmtSel(fmtSel),
    .chkCond(chkCond), .senseKey(senseKey), .senseAsc(senseAsc), .growCount(growCount),
    .growFull(growFull));
  fmtdl_initiator host_u (.clk(clk), .sys_rst(sys_rst), .inValid(inValid),
    .inReady(inReady), .inByte(inByte), .outReady(outReady), .slowMode(slowMode));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [31:0] phys_of(input logic [31:0] lba);
    return lba + (lba >> CYL_SHIFT) * SPARES_PER_CYL;
  endfunction : phys_of

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // results are sampled at the edge, before that edge's updates land
  always @(posedge clk) begin
    if (!sys_rst) begin
      if (outValid && outReady) got.push_back(outDefect.lba);
      if (outValid && outReady) check(outDefect.phys, phys_of(outDefect.lba));
      if (outValid && outReady) begin
        slipUse = ((outDefect.lba >> CYL_SHIFT) == slipCyl && slipUse != 0) ? slipUse + 1 : 1;
        slipCyl = outDefect.lba >> CYL_SHIFT;
        check(outDefect.slip, slipUse <= SPARES_PER_CYL);
      end
      if (fmtGo) goCnt++;
      if (fmtGo) selSeen = fmtSel;
      if (chkCond) chkCnt++;
      if (chkCond) ascSeen = senseAsc;
      if (chkCond) keySeen = senseKey;
      if (dataOutReq) reqSeen = 1'b1;
    end
  end

  // one command, optional header and descriptors; asc zero means success expected
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b5,
                     input logic [7:0] h1, input logic [15:0] len, input int n,
                     input logic [7:0] asc);
    logic [7:0] pat;
    logic fill;
    int i;
    goCnt = 0;
    chkCnt = 0;
    reqSeen = 1'b0;
    got.delete();
    slipUse = 0;
    expQ.delete();
    r = rnd();
    pat = r[7:0];
    fill = r[8];
    @(posedge clk);
    fillModeEn <= fill;
    slowMode <= r[9];
    host_u.send(op);
    host_u.send(b1);
    host_u.send(pat);
    host_u.send(r[23:16]); // interleave is ignored
    host_u.send(r[31:24]);
    host_u.send(b5);
    if (b1[4] && (asc == 8'h00 || asc == ASC_BAD_LIST)) begin
      host_u.send(8'h00);
      host_u.send(h1);
      host_u.send(len[15:8]);
      host_u.send(len[7:0]);
    end
    for (i = 0; i < n && asc == 8'h00; i++) begin
      // a long list opens with one crowded cylinder so that its spares run out
      r = rnd() & ((n > 4 && i < 6) ? 32'h0000_00FF : 32'h00FF_FFFF);
      expQ.push_back(r);
      host_u.send(r[31:24]);
      host_u.send(r[23:16]);
      host_u.send(r[15:8]);
      host_u.send(r[7:0]);
    end
    for (i = 0; i < 600 && goCnt + chkCnt == 0; i++) @(posedge clk);
    for (i = 0; i < 60 && (outValid || chkCnt + goCnt == 0); i++) @(posedge clk);
    @(posedge clk);
    #1;
    check(goCnt + chkCnt, 1);
    check(reqSeen, b1[4] && asc != ASC_BAD_OP && asc != ASC_BAD_CDB);
    if (asc != 8'h00) begin
      check({chkCnt[3:0], keySeen, ascSeen}, {4'h1, SENSE_ILLEGAL, asc});
      check(got.size(), 0);
    end else begin
      e.usePrimary = !b1[4] || !(h1[7] && h1[6]);
      e.useGrown = !b1[4] || !b1[3];
      e.useSupplied = b1[4] && n > 0;
      e.clearGrown = b1[4] && b1[3];
      e.fillEn = fill;
      e.fillPat = pat;
      check(selSeen, e);
      check(got.size(), expQ.size());
      for (i = 0; i < got.size() && i < expQ.size(); i++) check(got[i], expQ[i]);
      if (e.clearGrown) gcExp = 0;
      gcExp = (gcExp + n > GROWN_DEPTH) ? GROWN_DEPTH : gcExp + n;
      check({growFull, growCount}, {gcExp == GROWN_DEPTH, gcExp[GROWN_AW:0]});
    end
  endtask : run

  initial begin
    #WATCH_NS;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] b1, h1;
    int k, n;
    seed = 32'h0000_E64A;
    n_errors = 0;
    num_checks = 0;
    gcExp = 0;
    sys_rst = 1'b1;
    fillModeEn = 1'b0;
    slowMode = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    run(OPC_FORMAT, 8'h00, 8'h00, 8'h00, 16'h0000, 0, 8'h00);
    run(8'h05, 8'h10, 8'h00, 8'h00, 16'h0000, 0, ASC_BAD_OP);
    run(OPC_FORMAT, 8'h30, 8'h00, 8'h00, 16'h0000, 0, ASC_BAD_CDB);
    run(OPC_FORMAT, 8'h11, 8'h00, 8'h00, 16'h0000, 0, ASC_BAD_CDB);
    run(OPC_FORMAT, 8'h10, 8'h01, 8'h00, 16'h0000, 0, ASC_BAD_CDB);
    run(OPC_FORMAT, 8'h10, 8'h00, 8'hC0, 16'h0003, 0, ASC_BAD_LIST);
    run(OPC_FORMAT, 8'h18, 8'h00, 8'h40, 16'h0000, 0, ASC_BAD_LIST);
    run(OPC_FORMAT, 8'h10, 8'h00, 8'hFF, 16'h0048, 18, 8'h00);
    run(OPC_FORMAT, 8'h18, 8'h00, 8'h00, 16'h0000, 0, 8'h00);
    for (k = 0; k < 40; k++) begin
      r = rnd();
      n = r[2] ? r[1:0] : 0;
      b1 = {3'h0, r[2], r[3], 3'h0};
      h1 = {r[4], r[4], r[10:5]};
      run(OPC_FORMAT, b1, 8'h00, h1, 16'(4 * n), n, 8'h00);
    end
    tally_and_finish();
  end
endmodule : fmtdl_decoder_test
